// ==== rtl/psmsq_defs.svh ====
// constants and register map of the power save mode sequencer
// Notes on behaviour
// - wait-for-interrupt with deep sleep clear enters light sleep.
// - sleep-on-handler-return enters the selected mode on lowest handler exit.
// - light sleep halts level-stopped modules regardless of clock mask bits.
// - unmasked sufficient-priority interrupt leaves light sleep, restores run mode.
// - interrupt from a clock-stopped module cannot wake light sleep.
// - deep wait and retention stop all clocks but enabled slow ones; core kept.
// - async wake raises wake interrupt with cause recorded, resumes run mode.
// - backup powers off core domain; backup domain and slow clock kept.
// - backup left on brown-out, watchdog or pin reset and enabled wakes.
// - backup wakes: irq edges, both brown-outs, calendar events, watchdog.
// - slow clock source select picks which slow oscillator feeds backup modules.
// - reset exit runs reset sequence, releases when supply stable, records cause.
// - wake exit resets core only, sets backup flag, records backup wake cause.
// - light sleep wake latency only when clock sources were stopped.
// - deep wake waits full regulation unless fast wakeup; oscillator selectable.
// - during fast wakeup the flash controller runs with one wait state.
// - backup wake latency is core reset latency or regulation settling, whichever ends later.
`ifndef PSMSQ_DEFS_SVH
`define PSMSQ_DEFS_SVH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define PSMSQ_OFF_CTRL 12'h000
`define PSMSQ_OFF_ASYNC_WAKE_ENABLE 12'h004
`define PSMSQ_OFF_STAT 12'h008
`define PSMSQ_OFF_WAKE_CAUSE 12'h00c
`define PSMSQ_OFF_RESET_CAUSE 12'h010
`define PSMSQ_OFF_BKWCAUSE 12'h014

// ----------------------------------------
// control fields
// ----------------------------------------
`define PSMSQ_CTRL_LVL_LSB 0
`define PSMSQ_CTRL_DEEP 2
`define PSMSQ_CTRL_EXIT 3
`define PSMSQ_CTRL_RET 4
`define PSMSQ_CTRL_BACKUP_SELECT 5
`define PSMSQ_CTRL_FAST 6
`define PSMSQ_CTRL_FOSC 7
`define PSMSQ_CTRL_SLOW_CLOCK_SOURCE_SELECT 8
`define PSMSQ_CTRL_RESET 9'h000

// ----------------------------------------
// reset cause bits
// ----------------------------------------
`define PSMSQ_RC_IOBOD 0
`define PSMSQ_RC_COREBOD 1
`define PSMSQ_RC_WDT 2
`define PSMSQ_RC_PIN 3
`define PSMSQ_RC_BACKUP_SELECT 4

// ----------------------------------------
// timing, in ns, and cycles at 8 ns
// ----------------------------------------
`define PSMSQ_CLK_NS 8
`define PSMSQ_CLKRST_NS 400
`define PSMSQ_CLKRST_CYC ((`PSMSQ_CLKRST_NS + `PSMSQ_CLK_NS - 1) / `PSMSQ_CLK_NS)
`define PSMSQ_CORERST_NS 800
`define PSMSQ_CORERST_CYC ((`PSMSQ_CORERST_NS + `PSMSQ_CLK_NS - 1) / `PSMSQ_CLK_NS)

`endif

// ==== rtl/psmsq_pkg.sv ====
// types of the power save mode sequencer
package psmsq_pkg;
	typedef enum logic [3:0] {
		PSMSQ_RUN = 4'h0,
		PSMSQ_LIGHT = 4'h1,
		PSMSQ_DEEP = 4'h2,
		PSMSQ_RETAIN = 4'h3,
		PSMSQ_BACKUP = 4'h4,
		PSMSQ_WAKE_CLK = 4'h5,
		PSMSQ_WAKE_REG = 4'h6,
		PSMSQ_CORE_RST = 4'h7
	} psmsq_state_t;
endpackage

// ==== rtl/psmsq_timer.sv ====
// down counter used for restart latencies
`timescale 1ns/1ps
module psmsq_timer #(
	parameter int W = 16
) (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic load,
	input wire logic [W-1:0] count,
	output logic done
);
	logic [W-1:0] cnt_q;

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			cnt_q <= '0;
		else if (load)
			cnt_q <= count;
		else if (cnt_q != '0)
			cnt_q <= cnt_q - 1'b1;
	end

	assign done = (cnt_q == '0) && !load;
endmodule

// ==== rtl/psmsq_top.sv ====
// power save mode sequencer with APB registers
//
// Local design decisions: the address map and register access over APB.
`timescale 1ns/1ps
`include "psmsq_defs.svh"
module psmsq_top #(
	parameter int NIRQ = 8,
	parameter int NAW = 8,
	parameter logic [15:0] CLKRST_CYC = 16'(`PSMSQ_CLKRST_CYC),
	parameter logic [15:0] CORERST_CYC = 16'(`PSMSQ_CORERST_CYC)
) (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic wait_for_interrupt_instr,
	input wire logic lowest_handler_return,
	input wire logic [NIRQ-1:0] irq_pending,
	input wire logic [NIRQ-1:0] irq_on_ahb_clock,
	input wire logic [NIRQ-1:0] irq_on_apb_clock,
	input wire logic [NIRQ-1:0] irq_on_src_clock,
	input wire logic [NAW-1:0] async_wake_event,
	input wire logic [NAW-1:0] async_wake_exempt,
	input wire logic [7:0] backup_wake_event,
	input wire logic [3:0] backup_reset_req,
	input wire logic regulator_ready,
	input wire logic fast_regulator_ready,
	input wire logic clock_sources_ready,
	input wire logic power_scaling_ready,
	output logic cpu_clk_en,
	output logic ahb_clk_en,
	output logic apb_clk_en,
	output logic src_clk_en,
	output logic system_rc_osc_en,
	output logic fast_rc_osc_sel,
	output logic slow_clock_source_select,
	output logic core_power_on,
	output logic core_reset_n,
	output logic chip_reset_n,
	output logic flash_one_wait,
	output logic wake_irq,
	output psmsq_pkg::psmsq_state_t mode
);
	import psmsq_pkg::*;

	// ----------------------------------------
	// registers and state
	// ----------------------------------------
	psmsq_state_t state_q;
	logic [8:0] ctrl_q;
	logic [NAW-1:0] async_wake_enable_q;
	logic [NAW-1:0] wake_cause_q;
	logic [4:0] reset_cause_q;
	logic [7:0] bkwcause_q;
	logic [31:0] prdata_q;
	logic bkreset_exit_q;
	logic fast_q;
	logic tmr_load;
	logic [15:0] tmr_count;
	logic tmr_done;
	logic enter_req;
	logic [NIRQ-1:0] irq_live;
	logic light_wake;
	logic [NAW-1:0] aw_hit;
	logic bk_wake;
	logic bk_reset;
	logic wr_en;
	logic rd_en;
	logic addr_ok;
	logic [1:0] lvl;
	logic stopped_srcs;

	assign lvl = ctrl_q[`PSMSQ_CTRL_LVL_LSB +: 2];

	// ----------------------------------------
	// APB slave, zero wait states
	// ----------------------------------------
	assign pready = 1'b1;
	assign addr_ok = (paddr == `PSMSQ_OFF_CTRL) || (paddr == `PSMSQ_OFF_ASYNC_WAKE_ENABLE) ||
		(paddr == `PSMSQ_OFF_STAT) || (paddr == `PSMSQ_OFF_WAKE_CAUSE) ||
		(paddr == `PSMSQ_OFF_RESET_CAUSE) || (paddr == `PSMSQ_OFF_BKWCAUSE);
	assign pslverr = psel && penable && !addr_ok;
	assign wr_en = psel && penable && pwrite && addr_ok;
	assign rd_en = psel && !penable && !pwrite;
	assign prdata = prdata_q;

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			prdata_q <= 32'h0000_0000;
		else if (rd_en)
		begin
			unique case (paddr)
				`PSMSQ_OFF_CTRL: prdata_q <= 32'(ctrl_q);
				`PSMSQ_OFF_ASYNC_WAKE_ENABLE: prdata_q <= 32'(async_wake_enable_q);
				`PSMSQ_OFF_STAT: prdata_q <= {23'h0, power_scaling_ready, fast_q, state_q, 3'h0};
				`PSMSQ_OFF_WAKE_CAUSE: prdata_q <= 32'(wake_cause_q);
				`PSMSQ_OFF_RESET_CAUSE: prdata_q <= 32'(reset_cause_q);
				`PSMSQ_OFF_BKWCAUSE: prdata_q <= 32'(bkwcause_q);
				default: prdata_q <= 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			ctrl_q <= `PSMSQ_CTRL_RESET;
		else if (wr_en && paddr == `PSMSQ_OFF_CTRL)
			ctrl_q <= pwdata[8:0];
	end

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			async_wake_enable_q <= '0;
		else if (wr_en && paddr == `PSMSQ_OFF_ASYNC_WAKE_ENABLE)
			async_wake_enable_q <= pwdata[NAW-1:0];
	end

	// ----------------------------------------
	// wake qualification
	// ----------------------------------------
	// an interrupt counts only if its source clock is running in this level
	assign irq_live = irq_pending & ~(irq_on_ahb_clock & {NIRQ{lvl >= 2'd1}})
		& ~(irq_on_apb_clock & {NIRQ{lvl >= 2'd2}})
		& ~(irq_on_src_clock & {NIRQ{lvl == 2'd3}});
	assign light_wake = |irq_live;
	// exempt sources (external irq, calendar) need no enable bit
	assign aw_hit = async_wake_event & (async_wake_enable_q | async_wake_exempt);
	assign bk_wake = |backup_wake_event;
	assign bk_reset = |backup_reset_req;
	assign enter_req = wait_for_interrupt_instr || (lowest_handler_return && ctrl_q[`PSMSQ_CTRL_EXIT]);
	assign stopped_srcs = (lvl == 2'd3);

	// ----------------------------------------
	// mode sequencer
	// ----------------------------------------
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			state_q <= PSMSQ_RUN;
		else
		begin
			unique case (state_q)
				PSMSQ_RUN:
					if (enter_req)
					begin
						if (!ctrl_q[`PSMSQ_CTRL_DEEP])
							state_q <= PSMSQ_LIGHT;
						else if (ctrl_q[`PSMSQ_CTRL_BACKUP_SELECT])
							state_q <= PSMSQ_BACKUP;
						else if (ctrl_q[`PSMSQ_CTRL_RET])
							state_q <= PSMSQ_RETAIN;
						else
							state_q <= PSMSQ_DEEP;
					end
				PSMSQ_LIGHT:
					if (light_wake)
						state_q <= stopped_srcs ? PSMSQ_WAKE_CLK : PSMSQ_RUN;
				PSMSQ_DEEP, PSMSQ_RETAIN:
					if (|aw_hit)
						state_q <= PSMSQ_WAKE_REG;
				PSMSQ_BACKUP:
					if (bk_reset || bk_wake)
						state_q <= PSMSQ_CORE_RST;
				PSMSQ_WAKE_CLK:
					if (tmr_done && clock_sources_ready)
						state_q <= PSMSQ_RUN;
				PSMSQ_WAKE_REG:
					if (fast_q ? fast_regulator_ready : regulator_ready)
						state_q <= PSMSQ_RUN;
				PSMSQ_CORE_RST:
					if (tmr_done && regulator_ready)
						state_q <= PSMSQ_RUN;
				default: state_q <= PSMSQ_RUN;
			endcase
		end
	end

	assign tmr_load = (state_q == PSMSQ_LIGHT && light_wake && stopped_srcs) ||
		(state_q == PSMSQ_BACKUP && (bk_reset || bk_wake));
	assign tmr_count = (state_q == PSMSQ_BACKUP) ? CORERST_CYC : CLKRST_CYC;

	psmsq_timer #(
		.W(16)
	) u_timer (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.load(tmr_load),
		.count(tmr_count),
		.done(tmr_done)
	);

	// ----------------------------------------
	// causes and wake flags
	// ----------------------------------------
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			fast_q <= 1'b0;
		else if (state_q == PSMSQ_RUN && enter_req)
			fast_q <= ctrl_q[`PSMSQ_CTRL_FAST];
		else if (state_q == PSMSQ_RUN && power_scaling_ready)
			fast_q <= 1'b0;
	end

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			bkreset_exit_q <= 1'b0;
		else if (state_q == PSMSQ_BACKUP && (bk_reset || bk_wake))
			bkreset_exit_q <= bk_reset;
	end

	// hardware set beats software write-one-to-clear
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			wake_cause_q <= '0;
		else if ((state_q == PSMSQ_DEEP || state_q == PSMSQ_RETAIN) && |aw_hit)
			wake_cause_q <= (wr_en && paddr == `PSMSQ_OFF_WAKE_CAUSE) ?
				((wake_cause_q & ~pwdata[NAW-1:0]) | aw_hit) : (wake_cause_q | aw_hit);
		else if (wr_en && paddr == `PSMSQ_OFF_WAKE_CAUSE)
			wake_cause_q <= wake_cause_q & ~pwdata[NAW-1:0];
	end

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			reset_cause_q <= 5'h00;
		else if (state_q == PSMSQ_BACKUP && bk_reset)
			reset_cause_q <= {1'b0, backup_reset_req};
		else if (state_q == PSMSQ_BACKUP && bk_wake)
			reset_cause_q <= 5'(1) << `PSMSQ_RC_BACKUP_SELECT;
		else if (wr_en && paddr == `PSMSQ_OFF_RESET_CAUSE)
			reset_cause_q <= reset_cause_q & ~pwdata[4:0];
	end

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			bkwcause_q <= 8'h00;
		else if (state_q == PSMSQ_BACKUP && bk_wake && !bk_reset)
			bkwcause_q <= backup_wake_event;
		else if (wr_en && paddr == `PSMSQ_OFF_BKWCAUSE)
			bkwcause_q <= bkwcause_q & ~pwdata[7:0];
	end

	// ----------------------------------------
	// clock, power and reset outputs
	// ----------------------------------------
	logic deep_like;
	assign deep_like = (state_q == PSMSQ_DEEP) || (state_q == PSMSQ_RETAIN) || (state_q == PSMSQ_BACKUP);

	always_comb
	begin
		cpu_clk_en = (state_q == PSMSQ_RUN);
		ahb_clk_en = (state_q == PSMSQ_RUN) || (state_q == PSMSQ_LIGHT && lvl == 2'd0);
		apb_clk_en = (state_q == PSMSQ_RUN) || (state_q == PSMSQ_LIGHT && lvl <= 2'd1);
		src_clk_en = !deep_like && !(state_q == PSMSQ_LIGHT && lvl == 2'd3);
		system_rc_osc_en = !deep_like;
	end

	assign fast_rc_osc_sel = fast_q && ctrl_q[`PSMSQ_CTRL_FOSC];
	assign flash_one_wait = fast_q;
	assign slow_clock_source_select = ctrl_q[`PSMSQ_CTRL_SLOW_CLOCK_SOURCE_SELECT];
	assign core_power_on = (state_q != PSMSQ_BACKUP);
	assign core_reset_n = (state_q != PSMSQ_BACKUP) && (state_q != PSMSQ_CORE_RST);
	assign chip_reset_n = !(state_q == PSMSQ_CORE_RST && bkreset_exit_q);
	assign wake_irq = |wake_cause_q;
	assign mode = state_q;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	sequence s_backup_exit;
		state_q == PSMSQ_BACKUP && (bk_reset || bk_wake);
	endsequence

	sequence s_deep_entry;
		state_q == PSMSQ_RUN && enter_req && ctrl_q[`PSMSQ_CTRL_DEEP] && !ctrl_q[`PSMSQ_CTRL_BACKUP_SELECT];
	endsequence

	sequence s_fast_exit;
		state_q == PSMSQ_WAKE_REG && fast_q && fast_regulator_ready;
	endsequence

	AST_LIGHT_ENTRY: assert property (@(posedge clk_sys) disable iff (!rst_n)
		state_q == PSMSQ_RUN && enter_req && !ctrl_q[`PSMSQ_CTRL_DEEP] |=> state_q == PSMSQ_LIGHT)
		else $error("light sleep not entered");
	AST_BACKUP_ENTRY: assert property (@(posedge clk_sys) disable iff (!rst_n)
		state_q == PSMSQ_RUN && enter_req && ctrl_q[`PSMSQ_CTRL_DEEP] && ctrl_q[`PSMSQ_CTRL_BACKUP_SELECT]
		|=> state_q == PSMSQ_BACKUP && !core_power_on)
		else $error("backup not entered");
	AST_LIGHT_EXIT: assert property (@(posedge clk_sys) disable iff (!rst_n)
		state_q == PSMSQ_LIGHT && light_wake && !stopped_srcs |=> cpu_clk_en)
		else $error("light sleep wake missed");
	AST_NO_STOPPED_WAKE: assert property (@(posedge clk_sys) disable iff (!rst_n)
		state_q == PSMSQ_LIGHT && lvl == 2'd2 && (irq_pending & ~(irq_on_ahb_clock | irq_on_apb_clock)) == '0
		|=> state_q == PSMSQ_LIGHT)
		else $error("wake from stopped clock");
	AST_DEEP_CLOCKS: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(state_q == PSMSQ_DEEP || state_q == PSMSQ_RETAIN) |-> !src_clk_en && !apb_clk_en && core_power_on)
		else $error("clocks running in deep wait");
	AST_WAKE_CAUSE: assert property (@(posedge clk_sys) disable iff (!rst_n)
		state_q == PSMSQ_DEEP && |aw_hit |=> wake_irq && state_q == PSMSQ_WAKE_REG)
		else $error("wake cause not recorded");
	AST_BACKUP_FLAG: assert property (@(posedge clk_sys) disable iff (!rst_n)
		s_backup_exit ##0 !bk_reset |=> reset_cause_q[`PSMSQ_RC_BACKUP_SELECT] ##1 !core_reset_n [*2])
		else $error("backup wake flag missing");
	AST_RESET_HOLD: assert property (@(posedge clk_sys) disable iff (!rst_n)
		s_backup_exit |=> !core_reset_n [*8])
		else $error("core reset released early");
	// the wait state must outlive the wake and hold into run mode
	AST_FLASH_WAIT: assert property (@(posedge clk_sys) disable iff (!rst_n)
		s_fast_exit |=> state_q == PSMSQ_RUN && flash_one_wait)
		else $error("flash wait state missing");
	AST_RETAIN_ENTRY: assert property (@(posedge clk_sys) disable iff (!rst_n)
		s_deep_entry ##0 ctrl_q[`PSMSQ_CTRL_RET] |=> state_q == PSMSQ_RETAIN && core_power_on)
		else $error("retention not entered");
	AST_DEEP_ENTRY: assert property (@(posedge clk_sys) disable iff (!rst_n)
		s_deep_entry ##0 !ctrl_q[`PSMSQ_CTRL_RET] |=> state_q == PSMSQ_DEEP && !system_rc_osc_en)
		else $error("deep wait not entered");
	AST_LEVEL_MASK: assert property (@(posedge clk_sys) disable iff (!rst_n)
		state_q == PSMSQ_LIGHT && lvl != 2'd0 |-> !ahb_clk_en && !cpu_clk_en)
		else $error("bus clock runs in light sleep");
	AST_CLOCK_RESTART: assert property (@(posedge clk_sys) disable iff (!rst_n)
		state_q == PSMSQ_LIGHT && light_wake && stopped_srcs |=> state_q == PSMSQ_WAKE_CLK ##1 !cpu_clk_en)
		else $error("clock restart latency skipped");
	AST_SLOW_WAKE_HOLD: assert property (@(posedge clk_sys) disable iff (!rst_n)
		state_q == PSMSQ_WAKE_REG && !fast_q && !regulator_ready |=> state_q == PSMSQ_WAKE_REG)
		else $error("woke before regulation ready");
	AST_RESET_CAUSE: assert property (@(posedge clk_sys) disable iff (!rst_n)
		s_backup_exit ##0 bk_reset |=> !chip_reset_n && reset_cause_q[3:0] == $past(backup_reset_req))
		else $error("reset cause not recorded");
	AST_BACKUP_WAKE_CAUSE: assert property (@(posedge clk_sys) disable iff (!rst_n)
		s_backup_exit ##0 !bk_reset |=> chip_reset_n && bkwcause_q == $past(backup_wake_event))
		else $error("backup wake cause not recorded");
	AST_CORE_RST_HOLD: assert property (@(posedge clk_sys) disable iff (!rst_n)
		state_q == PSMSQ_CORE_RST && !regulator_ready |=> state_q == PSMSQ_CORE_RST && !core_reset_n)
		else $error("core reset left before supply stable");
endmodule

// ==== verif/psmsq_core_model.sv ====
// processor core and supply model facing the sequencer
`timescale 1ns/1ps
module psmsq_core_model
	import psmsq_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic [7:0] dly,
	input wire psmsq_pkg::psmsq_state_t mode,
	output logic wait_for_interrupt_instr,
	output logic lowest_handler_return,
	output logic regulator_ready,
	output logic fast_regulator_ready,
	output logic clock_sources_ready,
	output logic power_scaling_ready
);
	logic [7:0] cnt_q;
	logic asleep;

	// ----------------------------------------
	// supplies and clock sources
	// ----------------------------------------
	// all drop in any sleep state; fast regulator settles one cycle after wake starts, the rest dly cycles
	assign asleep = mode inside {PSMSQ_LIGHT, PSMSQ_DEEP, PSMSQ_RETAIN, PSMSQ_BACKUP};
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			cnt_q <= 8'h00;
		else if (asleep)
			cnt_q <= 8'h00;
		else if (cnt_q != 8'hff)
			cnt_q <= cnt_q + 8'h01;
	end
	assign regulator_ready = cnt_q >= dly;
	assign fast_regulator_ready = cnt_q != 8'h00;
	assign clock_sources_ready = cnt_q >= dly;
	// full scaling readiness lags the fast one, so software stays on the fast oscillator
	assign power_scaling_ready = cnt_q >= dly;

	// ----------------------------------------
	// instruction pulses
	// ----------------------------------------
	initial
	begin
		wait_for_interrupt_instr = 1'b0;
		lowest_handler_return = 1'b0;
	end
	task automatic pulse(input logic on_return);
		@(posedge clk_sys);
		if (on_return)
			lowest_handler_return <= 1'b1;
		else
			wait_for_interrupt_instr <= 1'b1;
		@(posedge clk_sys);
		wait_for_interrupt_instr <= 1'b0;
		lowest_handler_return <= 1'b0;
	endtask
endmodule

// ==== verif/test_power_save_mode_sequencer.sv ====
// self-checking bench of the power save mode sequencer
`timescale 1ns/1ps
`include "psmsq_defs.svh"
module test_power_save_mode_sequencer;
	import psmsq_pkg::*;
	localparam int CLKRST = 4;
	localparam int CORERST = 9;
	logic clk_sys = 1'b0;
	logic rst_n, psel, penable, pwrite, pready, pslverr, e;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, d;
	logic wait_for_interrupt_instr, lowest_handler_return;
	logic [7:0] irq_pending, irq_on_ahb_clock, irq_on_apb_clock, irq_on_src_clock;
	logic [7:0] async_wake_event, async_wake_exempt, backup_wake_event, dly;
	logic [3:0] backup_reset_req;
	logic regulator_ready, fast_regulator_ready, clock_sources_ready, power_scaling_ready;
	logic cpu_clk_en, ahb_clk_en, apb_clk_en, src_clk_en, system_rc_osc_en, fast_rc_osc_sel;
	logic slow_clock_source_select, core_power_on, core_reset_n, chip_reset_n, flash_one_wait, wake_irq;
	psmsq_state_t mode;
	int n;
	int errors = 0;
	int samples_checked = 0;

	always #4 clk_sys = ~clk_sys;

	psmsq_top #(.NIRQ(8), .NAW(8), .CLKRST_CYC(16'(CLKRST)), .CORERST_CYC(16'(CORERST))) u_dut (
		.clk_sys, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
		.wait_for_interrupt_instr, .lowest_handler_return, .irq_pending, .irq_on_ahb_clock,
		.irq_on_apb_clock, .irq_on_src_clock, .async_wake_event, .async_wake_exempt,
		.backup_wake_event, .backup_reset_req, .regulator_ready, .fast_regulator_ready,
		.clock_sources_ready, .power_scaling_ready, .cpu_clk_en, .ahb_clk_en, .apb_clk_en,
		.src_clk_en, .system_rc_osc_en, .fast_rc_osc_sel, .slow_clock_source_select,
		.core_power_on, .core_reset_n, .chip_reset_n, .flash_one_wait, .wake_irq, .mode);

	psmsq_core_model u_core (.clk_sys, .rst_n, .dly, .mode, .wait_for_interrupt_instr,
		.lowest_handler_return, .regulator_ready, .fast_regulator_ready, .clock_sources_ready,
		.power_scaling_ready);

	// ----------------------------------------
	// checking and closing
	// ----------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic end_sim();
		$display("comparisons %0d mismatches %0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// ----------------------------------------
	// bus and wait tasks
	// ----------------------------------------
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
		output logic [31:0] rd, output logic err);
		int k;
		@(posedge clk_sys);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge clk_sys);
		penable <= 1'b1;
		k = 0;
		do
		begin
			@(posedge clk_sys);
			k++;
		end
		while (pready !== 1'b1 && k < 16);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (pready !== 1'b1)
		begin
			errors++;
			end_sim();
		end
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] v);
		apb(1'b1, a, v, d, e);
	endtask
	task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0, d, e);
		chk(d, exp);
	endtask
	// counts falling edges until the mode shows up
	task automatic wait_mode(input psmsq_state_t m, output int cnt);
		cnt = 0;
		do
		begin
			@(negedge clk_sys);
			cnt++;
		end
		while (mode !== m && cnt < 300);
		if (mode !== m)
		begin
			errors++;
			end_sim();
		end
	endtask
	// inputs change only just after a rising edge
	task automatic drive(input logic [7:0] irq, input logic [7:0] aw, input logic [7:0] ex);
		@(posedge clk_sys);
		irq_pending <= irq;
		async_wake_event <= aw;
		async_wake_exempt <= ex;
	endtask

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	initial
	begin
		{psel, penable, pwrite, paddr, pwdata} = '0;
		{irq_pending, irq_on_ahb_clock, irq_on_apb_clock, irq_on_src_clock} = '0;
		{async_wake_event, async_wake_exempt, backup_wake_event, backup_reset_req} = '0;
		dly = 8'd3;
		rst_n = 1'b0;
		repeat (8) @(posedge clk_sys);
		rst_n <= 1'b1;
		chk(mode, PSMSQ_RUN);
		rdc(`PSMSQ_OFF_RESET_CAUSE, 32'h0);
		apb(1'b0, 12'h0f0, 32'h0, d, e);
		chk(d, 32'h0);
		chk(32'(e), 32'h1);
		$display("test reset finished");
		for (int lv = 0; lv < 4; lv++)
		begin
			irq_on_ahb_clock <= {7'h0, lv == 1};
			irq_on_apb_clock <= {7'h0, lv == 2};
			irq_on_src_clock <= {6'h0, lv < 3, lv == 3};
			wr(`PSMSQ_OFF_CTRL, 32'(lv));
			u_core.pulse(1'b0);
			wait_mode(PSMSQ_LIGHT, n);
			chk({cpu_clk_en, ahb_clk_en, apb_clk_en, src_clk_en, system_rc_osc_en}, {1'b0, lv < 1, lv < 2, lv < 3, 1'b1});
			if (lv > 0)
			begin
				drive(8'h01, 8'h00, 8'h00);
				repeat (6) @(negedge clk_sys);
				chk(mode, PSMSQ_LIGHT);
			end
			drive(8'h03, 8'h00, 8'h00);
			wait_mode(PSMSQ_RUN, n);
			chk(lv == 3 ? n >= CLKRST : n <= 3, 1);
			drive(8'h00, 8'h00, 8'h00);
		end
		u_core.pulse(1'b1);
		repeat (4) @(negedge clk_sys);
		chk(mode, PSMSQ_RUN);
		wr(`PSMSQ_OFF_CTRL, 32'h8);
		u_core.pulse(1'b1);
		wait_mode(PSMSQ_LIGHT, n);
		drive(8'h02, 8'h00, 8'h00);
		wait_mode(PSMSQ_RUN, n);
		drive(8'h00, 8'h00, 8'h00);
		$display("test light sleep finished");
		dly <= 8'd20;
		wr(`PSMSQ_OFF_ASYNC_WAKE_ENABLE, 32'h1);
		wr(`PSMSQ_OFF_CTRL, 32'h4);
		u_core.pulse(1'b0);
		wait_mode(PSMSQ_DEEP, n);
		chk({cpu_clk_en, ahb_clk_en, apb_clk_en, src_clk_en, system_rc_osc_en, core_power_on}, 6'h01);
		drive(8'h00, 8'h02, 8'h00);
		repeat (6) @(negedge clk_sys);
		chk(mode, PSMSQ_DEEP);
		drive(8'h00, 8'h01, 8'h00);
		wait_mode(PSMSQ_WAKE_REG, n);
		chk(wake_irq, 1);
		drive(8'h00, 8'h00, 8'h00);
		wait_mode(PSMSQ_RUN, n);
		chk(n >= 15, 1);
		rdc(`PSMSQ_OFF_WAKE_CAUSE, 32'h1);
		wr(`PSMSQ_OFF_WAKE_CAUSE, 32'h1);
		rdc(`PSMSQ_OFF_WAKE_CAUSE, 32'h0);
		wr(`PSMSQ_OFF_CTRL, 32'hd4);
		u_core.pulse(1'b0);
		wait_mode(PSMSQ_RETAIN, n);
		drive(8'h00, 8'h04, 8'h04);
		wait_mode(PSMSQ_WAKE_REG, n);
		chk(fast_rc_osc_sel, 1);
		drive(8'h00, 8'h00, 8'h04);
		wait_mode(PSMSQ_RUN, n);
		chk({n <= 3, flash_one_wait}, 2'h3);
		rdc(`PSMSQ_OFF_STAT, 32'h80);
		repeat (30) @(negedge clk_sys);
		chk(flash_one_wait, 0);
		rdc(`PSMSQ_OFF_STAT, 32'h100);
		rdc(`PSMSQ_OFF_WAKE_CAUSE, 32'h4);
		$display("test deep wait and retention finished");
		dly <= 8'd2;
		for (int i = 0; i < 12; i++)
		begin
			wr(`PSMSQ_OFF_CTRL, 32'h124);
			u_core.pulse(1'b0);
			wait_mode(PSMSQ_BACKUP, n);
			chk({core_power_on, slow_clock_source_select}, 2'h1);
			@(posedge clk_sys);
			backup_wake_event <= (i < 8) ? 8'(1 << i) : 8'h00;
			backup_reset_req <= (i < 8) ? 4'h0 : 4'(1 << (i - 8));
			wait_mode(PSMSQ_CORE_RST, n);
			chk({core_reset_n, chip_reset_n}, {1'b0, i < 8});
			@(posedge clk_sys);
			backup_wake_event <= 8'h00;
			backup_reset_req <= 4'h0;
			wait_mode(PSMSQ_RUN, n);
			chk(n >= CORERST - 2, 1);
			rdc(`PSMSQ_OFF_RESET_CAUSE, (i < 8) ? 32'h10 : 32'(1 << (i - 8)));
			rdc(`PSMSQ_OFF_BKWCAUSE, (i < 8) ? 32'(1 << i) : 32'h0);
			wr(`PSMSQ_OFF_BKWCAUSE, 32'hff);
		end
		$display("test backup finished");
		end_sim();
	end
endmodule
